// *** design/ust_trigger.sv ***
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ust_map.svh"
// Summary of operation
// - Five to nine bits, parity, stop choices.
// - Even or odd parity bit expectation.
// - Idle gap separates one frame from next.
// - Start-bit mode fires on first low.
// - Frame-start mode needs idle gap first.
// - Frame-error mode fires on framing errors.
// - Symbol mode fires on nth symbol.
// - Break mode fires on long low line.
// - Parity-error mode fires on parity mismatch.
// - Pattern mode matches run at offset.
// - Any-symbol mode fires on any symbol that matches pattern 0.
// - Skip zero to 4095 leading symbols.
// - Pattern length one to four symbols.
// - Pattern writes beyond length grow it.
// - Pattern bits may be don't-care.
// - Trigger source is transmit or receive.
// - Report start time, data, frame state.
module ust_trigger
  import ust_pkg::*;
#(
  parameter int DIV_W  = 16,
  parameter int IDLE_W = 24
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               rx_line_i,
  input  wire logic               tx_line_i,
  output logic                    trig_o,
  output logic                    word_valid_o,
  output logic      [`UST_DW-1:0] word_o
);

  if (DIV_W < 4 || DIV_W > 32 || IDLE_W < 4 || IDLE_W > 32) begin : g_bad_width
    $error("Divider and idle widths must lie between 4 and 32.");
  end

  ust_ctrl_t           ctrl_r,   ctrl_nxt;
  ust_fmt_t            fmt_r,    fmt_nxt;
  logic [DIV_W-1:0]    div_r,    div_nxt;
  logic [IDLE_W-1:0]   idle_r,   idle_nxt;
  ust_seq_t            seq_r,    seq_nxt;
  ust_pat_t            pat_r     [`UST_NPAT];
  ust_pat_t            pat_nxt   [`UST_NPAT];
  logic                tseen_r,  tseen_nxt;
  logic                ack_r,    ack_nxt;
  logic [31:0]         dat_r,    dat_nxt;
  logic [31:0]         rdata;
  logic [31:0]         wmerge;
  logic [7:0]          wadr;
  logic [1:0]          pidx;

  logic                line;
  ust_rx_evt_t         evt;
  logic                rx_busy;
  logic [IDLE_W-1:0]   icnt_r,   icnt_nxt;
  logic [`UST_OFFS_W-1:0] idx_r, idx_nxt;
  logic                run_r,    run_nxt;
  ust_fstate_t         fst_r,    fst_nxt;
  logic                fact_r,   fact_nxt;
  logic [31:0]         ts_r,     ts_nxt;
  logic [31:0]         fts_r,    fts_nxt;
  logic [31:0]         tts_r,    tts_nxt;
  logic                trig_r,   trig_nxt;
  logic                wv_r,     wv_nxt;
  logic [`UST_DW-1:0]  word_r,   word_nxt;
  logic                idle_ok;
  logic                frame_new;
  logic                in_win;
  logic                last_pos;
  logic                sym_hit;
  logic                run_ok;
  logic [`UST_OFFS_W:0] pos;
  ust_fstate_t         sym_st;

  function automatic logic [31:0] ust_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < `UST_NBYTES; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    ust_merge = res;
  endfunction : ust_merge

  // The selected line passes straight to the sampler; the pins are already synchronous to the clock.
  assign line = (ctrl_r.use_tx ? tx_line_i : rx_line_i) ^ ctrl_r.invert;

  ust_symbol_rx #(
    .DIV_W (DIV_W)
  ) u_rx (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .line_i  (line),
    .div_i   (div_r),
    .fmt_i   (fmt_r),
    .evt_o   (evt),
    .busy_o  (rx_busy)
  );

  assign wadr = {wb_adr_i[7:2], 2'b00};
  assign pidx = 2'((wadr - `UST_OFF_PAT0) >> 2);

  always_comb begin
    ctrl_nxt  = ctrl_r;
    fmt_nxt   = fmt_r;
    div_nxt   = div_r;
    idle_nxt  = idle_r;
    seq_nxt   = seq_r;
    pat_nxt   = pat_r;
    dat_nxt   = dat_r;
    rdata     = '0;
    wmerge    = '0;
    // A trigger in the cycle of a clearing write keeps the flag set.
    tseen_nxt = tseen_r | trig_r;
    ack_nxt   = wb_cyc_i & wb_stb_i & ~ack_r;
    unique case (wadr)
      `UST_OFF_CTRL:   rdata = ctrl_r;
      `UST_OFF_FMT:    rdata = fmt_r;
      `UST_OFF_DIV:    rdata = 32'(div_r);
      `UST_OFF_IDLE:   rdata = 32'(idle_r);
      `UST_OFF_SEQ:    rdata = seq_r;
      `UST_OFF_STAT:   rdata = ust_stat_t'({29'h0000_0000, fact_r, rx_busy, tseen_r});
      `UST_OFF_FSTART: rdata = fts_r - tts_r;
      `UST_OFF_FDATA:  rdata = ust_fdata_t'({6'h00, fst_r, idx_r, 3'h0, word_r});
      default: begin
        if (wadr >= `UST_OFF_PAT0 && wadr <= `UST_OFF_PAT3) begin
          rdata = pat_r[pidx];
        end
      end
    endcase
    if (ack_nxt) begin
      if (wb_we_i) begin
        wmerge = ust_merge(rdata, wb_dat_i, wb_sel_i);
        unique case (wadr)
          `UST_OFF_CTRL: begin
            ctrl_nxt     = ust_ctrl_t'(wmerge);
            ctrl_nxt.rsv = '0;
          end
          `UST_OFF_FMT: begin
            fmt_nxt     = ust_fmt_t'(wmerge);
            fmt_nxt.rsv = '0;
          end
          `UST_OFF_DIV:  div_nxt  = wmerge[DIV_W-1:0];
          `UST_OFF_IDLE: idle_nxt = wmerge[IDLE_W-1:0];
          `UST_OFF_SEQ: begin
            seq_nxt     = ust_seq_t'(wmerge);
            seq_nxt.rsv = '0;
            if (seq_nxt.plen < `UST_PLEN_MIN) begin
              seq_nxt.plen = `UST_PLEN_MIN;
            end else if (seq_nxt.plen > `UST_PLEN_MAX) begin
              seq_nxt.plen = `UST_PLEN_MAX;
            end
          end
          `UST_OFF_STAT: begin
            if (wmerge[0] && !trig_r) begin
              tseen_nxt = 1'b0;
            end
          end
          default: begin
            if (wadr >= `UST_OFF_PAT0 && wadr <= `UST_OFF_PAT3) begin
              pat_nxt[pidx]      = ust_pat_t'(wmerge);
              pat_nxt[pidx].rsv1 = '0;
              pat_nxt[pidx].rsv0 = '0;
              if ({1'b0, pidx} >= seq_r.plen) begin
                seq_nxt.plen = 3'({1'b0, pidx} + 1'b1);
              end
            end
          end
        endcase
      end else begin
        dat_nxt = rdata;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_r  <= '0;
      fmt_r   <= '0;
      div_r   <= DIV_W'(`UST_DIV_RST);
      idle_r  <= IDLE_W'(`UST_IDLE_RST);
      seq_r   <= ust_seq_t'({17'h0_0000, `UST_PLEN_RST, 12'h000});
      pat_r   <= '{default: '0};
      tseen_r <= 1'b0;
      ack_r   <= 1'b0;
      dat_r   <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      fmt_r   <= fmt_nxt;
      div_r   <= div_nxt;
      idle_r  <= idle_nxt;
      seq_r   <= seq_nxt;
      pat_r   <= pat_nxt;
      tseen_r <= tseen_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Offset and index are compared one bit wider so that a large offset never wraps into the window.
  assign idle_ok   = (icnt_r >= idle_r);
  assign frame_new = evt.start & idle_ok;
  assign pos       = {1'b0, idx_r} - {1'b0, seq_r.offset};
  assign in_win    = (idx_r >= seq_r.offset) && (pos < (`UST_OFFS_W+1)'(seq_r.plen));
  assign last_pos  = (pos == (`UST_OFFS_W+1)'(seq_r.plen - 1'b1));
  assign sym_hit   = ust_match(evt.data, pat_r[pos[1:0]]);
  assign run_ok    = ((pos == '0) ? 1'b1 : run_r) & sym_hit;
  assign sym_st    = evt.brk ? UST_FS_BRK : evt.frm_err ? UST_FS_FERR : evt.par_err ? UST_FS_PERR : UST_FS_OK;

  always_comb begin
    icnt_nxt = icnt_r;
    idx_nxt  = idx_r;
    run_nxt  = run_r;
    fst_nxt  = fst_r;
    fact_nxt = fact_r;
    fts_nxt  = fts_r;
    tts_nxt  = tts_r;
    ts_nxt   = ts_r + 1'b1;
    wv_nxt   = evt.sym;
    word_nxt = evt.sym ? evt.data : word_r;
    trig_nxt = 1'b0;
    // The count is held, not cleared, as the line falls, so the start event a cycle later still sees the gap.
    if (rx_busy) begin
      icnt_nxt = '0;
    end else if (line && icnt_r != '1) begin
      icnt_nxt = icnt_r + 1'b1;
    end
    if (frame_new) begin
      idx_nxt  = '0;
      fst_nxt  = UST_FS_OK;
      fact_nxt = 1'b1;
      fts_nxt  = ts_r;
    end else if (evt.sym) begin
      if (idx_r != '1) begin
        idx_nxt = idx_r + 1'b1;
      end
      if (in_win) begin
        run_nxt = run_ok;
      end
      if (sym_st > fst_r) begin
        fst_nxt = sym_st;
      end
    end
    if (idle_ok && !rx_busy) begin
      fact_nxt = 1'b0;
    end
    unique case (ctrl_r.mode)
      UST_M_START:   trig_nxt = evt.start;
      UST_M_FRAME:   trig_nxt = frame_new;
      UST_M_FERR:    trig_nxt = evt.frm_err;
      UST_M_SYMBOL:  trig_nxt = evt.sym && (idx_r == seq_r.offset);
      UST_M_BREAK:   trig_nxt = evt.brk;
      UST_M_PERR:    trig_nxt = evt.sym && evt.par_err;
      UST_M_PATTERN: trig_nxt = evt.sym && in_win && last_pos && run_ok;
      UST_M_ANY:     trig_nxt = evt.sym && ust_match(evt.data, pat_r[0]);
    endcase
    trig_nxt = trig_nxt & ctrl_r.enable;
    if (trig_nxt) begin
      tts_nxt = ts_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      icnt_r <= '1;
      idx_r  <= '0;
      run_r  <= 1'b0;
      fst_r  <= UST_FS_OK;
      fact_r <= 1'b0;
      ts_r   <= '0;
      fts_r  <= '0;
      tts_r  <= '0;
      trig_r <= 1'b0;
      wv_r   <= 1'b0;
      word_r <= '0;
    end else begin
      icnt_r <= icnt_nxt;
      idx_r  <= idx_nxt;
      run_r  <= run_nxt;
      fst_r  <= fst_nxt;
      fact_r <= fact_nxt;
      ts_r   <= ts_nxt;
      fts_r  <= fts_nxt;
      tts_r  <= tts_nxt;
      trig_r <= trig_nxt;
      wv_r   <= wv_nxt;
      word_r <= word_nxt;
    end
  end

  assign trig_o       = trig_r;
  assign word_valid_o = wv_r;
  assign word_o       = word_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  chk_start_fire: assert property (
    ctrl_r.enable && ctrl_r.mode == UST_M_START && evt.start |=> trig_o)
    else $error("Start bit did not fire the trigger.");
  chk_frame_gap: assert property (
    trig_o && $past(ctrl_r.mode) == UST_M_FRAME |-> $past(icnt_r >= idle_r) && $past(evt.start))
    else $error("Frame start fired without the idle gap.");
  chk_ferr_fire: assert property (
    ctrl_r.enable && ctrl_r.mode == UST_M_FERR && evt.frm_err |=> trig_o)
    else $error("Framing error did not fire the trigger.");
  chk_symbol_pos: assert property (
    trig_o && $past(ctrl_r.mode) == UST_M_SYMBOL |-> $past(idx_r) == $past(seq_r.offset))
    else $error("Symbol trigger at the wrong position.");
  chk_break_fire: assert property (
    ctrl_r.enable && ctrl_r.mode == UST_M_BREAK && evt.brk |=> trig_o ##1 !trig_o)
    else $error("Break did not give one trigger pulse.");
  chk_perr_fire: assert property (
    trig_o && $past(ctrl_r.mode) == UST_M_PERR |-> $past(evt.par_err) && $past(evt.sym))
    else $error("Parity trigger without a parity error.");
  chk_plen_range: assert property (
    seq_r.plen >= `UST_PLEN_MIN && seq_r.plen <= `UST_PLEN_MAX)
    else $error("Pattern length out of range.");
  chk_plen_grow: assert property (
    wb_ack_o && $past(wb_we_i) && $past(wadr) == `UST_OFF_PAT3 |-> seq_r.plen == `UST_PLEN_MAX)
    else $error("Pattern length did not grow to cover the write.");
  chk_trig_sticky: assert property (
    trig_o |=> tseen_r && tts_r == $past(ts_r, 2))
    else $error("Trigger not recorded with its time.");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held longer than one cycle.");

endmodule : ust_trigger

// *** design/ust_map.svh ***
`ifndef UST_MAP_SVH
`define UST_MAP_SVH

`define UST_OFF_CTRL   8'h00
`define UST_OFF_FMT    8'h04
`define UST_OFF_DIV    8'h08
`define UST_OFF_IDLE   8'h0C
`define UST_OFF_SEQ    8'h10
`define UST_OFF_PAT0   8'h14
`define UST_OFF_PAT3   8'h20
`define UST_OFF_STAT   8'h24
`define UST_OFF_FSTART 8'h28
`define UST_OFF_FDATA  8'h2C

`define UST_DIV_RST    16'h0364
`define UST_IDLE_RST   24'h00_21E8
`define UST_PLEN_RST   3'h1
`define UST_PLEN_MIN   3'h1
`define UST_PLEN_MAX   3'h4
`define UST_NB_BASE    4'h5
`define UST_NB_MAX     4'h9
`define UST_DBITS_MAX  3'h4
`define UST_DW         9
`define UST_OFFS_W     12
`define UST_NPAT       4
`define UST_NBYTES     4

`endif

// *** design/ust_pkg.sv ***
`include "ust_map.svh"
package ust_pkg;

  typedef enum logic [2:0] {
    UST_M_START, UST_M_FRAME, UST_M_FERR, UST_M_SYMBOL,
    UST_M_BREAK, UST_M_PERR, UST_M_PATTERN, UST_M_ANY
  } ust_mode_t;
  typedef enum logic [1:0] {UST_PAR_NONE, UST_PAR_EVEN, UST_PAR_ODD, UST_PAR_RSV} ust_par_t;
  typedef enum logic [1:0] {UST_STOP_1, UST_STOP_15, UST_STOP_2, UST_STOP_RSV} ust_stop_t;
  typedef enum logic [1:0] {UST_FS_OK, UST_FS_PERR, UST_FS_FERR, UST_FS_BRK} ust_fstate_t;

  typedef struct packed {
    logic [25:0] rsv;
    ust_mode_t   mode;
    logic        invert;
    logic        use_tx;
    logic        enable;
  } ust_ctrl_t;

  typedef struct packed {
    logic [24:0] rsv;
    ust_stop_t   stop;
    ust_par_t    parity;
    logic [2:0]  dbits;
  } ust_fmt_t;

  typedef struct packed {
    logic [16:0]            rsv;
    logic [2:0]             plen;
    logic [`UST_OFFS_W-1:0] offset;
  } ust_seq_t;

  typedef struct packed {
    logic [6:0]         rsv1;
    logic [`UST_DW-1:0] care;
    logic [6:0]         rsv0;
    logic [`UST_DW-1:0] val;
  } ust_pat_t;

  typedef struct packed {
    logic [28:0] rsv;
    logic        frame_act;
    logic        busy;
    logic        trig;
  } ust_stat_t;

  typedef struct packed {
    logic [5:0]             rsv1;
    ust_fstate_t            state;
    logic [`UST_OFFS_W-1:0] idx;
    logic [2:0]             rsv0;
    logic [`UST_DW-1:0]     data;
  } ust_fdata_t;

  typedef struct packed {
    logic               start;
    logic               sym;
    logic [`UST_DW-1:0] data;
    logic               par_err;
    logic               frm_err;
    logic               brk;
  } ust_rx_evt_t;

  function automatic logic ust_match(input logic [`UST_DW-1:0] d, input ust_pat_t p);
    ust_match = (((d ^ p.val) & p.care) == '0);
  endfunction : ust_match

endpackage : ust_pkg

// *** design/ust_symbol_rx.sv ***
`timescale 1ns/1ps
`include "ust_map.svh"
module ust_symbol_rx
  import ust_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             line_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire ust_fmt_t         fmt_i,
  output ust_rx_evt_t           evt_o,
  output logic                  busy_o
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_XSTOP, RX_WAITHI} ust_rx_st_t;

  ust_rx_st_t         st_r,    st_nxt;
  logic [DIV_W-1:0]   cnt_r,   cnt_nxt;
  logic [3:0]         bit_r,   bit_nxt;
  logic [`UST_DW-1:0] sh_r,    sh_nxt;
  logic               par_r,   par_nxt;
  logic               perr_r,  perr_nxt;
  logic               low_r,   low_nxt;
  ust_rx_evt_t        evt_r,   evt_nxt;
  logic               tick;
  logic [3:0]         nb;

  assign tick   = (cnt_r == '0);
  assign nb     = (fmt_i.dbits > `UST_DBITS_MAX) ? `UST_NB_MAX : 4'(`UST_NB_BASE + {1'b0, fmt_i.dbits});
  assign busy_o = (st_r != RX_IDLE);
  assign evt_o  = evt_r;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = tick ? cnt_r : cnt_r - 1'b1;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    par_nxt  = par_r;
    perr_nxt = perr_r;
    low_nxt  = low_r;
    evt_nxt  = '0;
    unique case (st_r)
      RX_IDLE: begin
        if (!line_i) begin
          evt_nxt.start = 1'b1;
          cnt_nxt       = div_i >> 1;
          st_nxt        = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          if (line_i) begin
            st_nxt = RX_IDLE;
          end else begin
            cnt_nxt  = div_i - 1'b1;
            bit_nxt  = '0;
            sh_nxt   = '0;
            par_nxt  = 1'b0;
            perr_nxt = 1'b0;
            low_nxt  = 1'b1;
            st_nxt   = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          sh_nxt[bit_r] = line_i;
          par_nxt       = par_r ^ line_i;
          low_nxt       = low_r & ~line_i;
          cnt_nxt       = div_i - 1'b1;
          bit_nxt       = bit_r + 1'b1;
          if (bit_r == nb - 1'b1) begin
            st_nxt = (fmt_i.parity == UST_PAR_EVEN || fmt_i.parity == UST_PAR_ODD) ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          perr_nxt = (fmt_i.parity == UST_PAR_ODD) ? (line_i == par_r) : (line_i != par_r);
          low_nxt  = low_r & ~line_i;
          cnt_nxt  = div_i - 1'b1;
          st_nxt   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          evt_nxt.sym     = 1'b1;
          evt_nxt.data    = sh_r;
          evt_nxt.par_err = perr_r;
          if (!line_i) begin
            evt_nxt.frm_err = 1'b1;
            evt_nxt.brk     = low_r;
            st_nxt          = RX_WAITHI;
          end else begin
            unique case (fmt_i.stop)
              UST_STOP_15: begin
                cnt_nxt = div_i >> 1;
                st_nxt  = RX_XSTOP;
              end
              UST_STOP_2: begin
                cnt_nxt = div_i - 1'b1;
                st_nxt  = RX_XSTOP;
              end
              default: st_nxt = RX_IDLE;
            endcase
          end
        end
      end
      RX_XSTOP: begin
        if (tick) begin
          st_nxt = RX_IDLE;
        end
      end
      RX_WAITHI: begin
        if (line_i) begin
          st_nxt = RX_IDLE;
        end
      end
      default: st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_r   <= RX_IDLE;
      cnt_r  <= '0;
      bit_r  <= '0;
      sh_r   <= '0;
      par_r  <= 1'b0;
      perr_r <= 1'b0;
      low_r  <= 1'b0;
      evt_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      par_r  <= par_nxt;
      perr_r <= perr_nxt;
      low_r  <= low_nxt;
      evt_r  <= evt_nxt;
    end
  end

  chk_stop_low_err: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    evt_o.frm_err |-> $past(st_r == RX_STOP && tick && !line_i))
    else $error("Framing error without a low stop sample.");

endmodule : ust_symbol_rx

// *** tb/ust_tx_model.sv ***
`timescale 1ns/1ps
module ust_tx_model
  import ust_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] div_i,
  input  wire ust_fmt_t    fmt_i,
  output logic             line_o
);
  // The line idles high from time zero, so the receiver never sees a false start.
  initial line_o = 1'b1;
  task automatic hold(input logic b, input int n);
    line_o <= b;
    repeat (n) @(posedge mclk_i);
  endtask : hold
  // A bad parity or a low stop bit is sent only when a scenario asks for it.
  task automatic send(input logic [8:0] d, input logic bad_p, input logic bad_s, input int gap);
    int   nb;
    int   ns;
    logic p;
    nb = (fmt_i.dbits > 3'h4) ? 9 : int'(fmt_i.dbits) + 5;
    ns = (fmt_i.stop == UST_STOP_15) ? 3 : (fmt_i.stop == UST_STOP_2) ? 4 : 2;
    p  = ^(d & ((9'h001 << nb) - 9'h001)) ^ (fmt_i.parity == UST_PAR_ODD) ^ bad_p;
    hold(1'b0, div_i);
    for (int i = 0; i < nb; i++) begin
      hold(d[i], div_i);
    end
    if (fmt_i.parity == UST_PAR_EVEN || fmt_i.parity == UST_PAR_ODD) begin
      hold(p, div_i);
    end
    if (bad_s) begin
      hold(1'b0, div_i);
    end
    hold(1'b1, int'(div_i) * ns / 2 + gap);
  endtask : send
endmodule : ust_tx_model

// *** tb/ust_trigger_tb_top.sv ***
`timescale 1ns/1ps
`include "ust_map.svh"
module ust_trigger_tb_top
  import ust_pkg::*;
;
  logic        mclk_i;
  logic        rst_b_i = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] rdata, rd_dat;
  logic        wb_ack, trig, word_vld, rx_line, tx_line;
  logic [8:0]  word;
  logic [8:0]  last_word = 9'h000;
  logic [15:0] div = 16'h0010;
  ust_fmt_t    fmt = ust_fmt_t'(32'h0000_0000);
  int          n_errors = 0, n_tests = 0, n_trig = 0;

  ust_trigger uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(rdata), .wb_ack_o(wb_ack),
    .rx_line_i(rx_line), .tx_line_i(tx_line), .trig_o(trig), .word_valid_o(word_vld), .word_o(word)
  );
  ust_tx_model rxm (.mclk_i(mclk_i), .div_i(div), .fmt_i(fmt), .line_o(rx_line));
  ust_tx_model txm (.mclk_i(mclk_i), .div_i(div), .fmt_i(fmt), .line_o(tx_line));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Pulses last one cycle, so they are counted at every edge rather than polled.
  always @(posedge mclk_i) begin
    if (trig === 1'b1) begin
      n_trig++;
    end
    if (word_vld === 1'b1) begin
      last_word = word;
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge mclk_i);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_cnt(input int exp);
    n_tests++;
    if (n_trig != exp) begin
      n_errors++;
      $display("Error at %0t: %0d triggers expected %0d", $time, n_trig, exp);
    end
  endtask : chk_cnt

  // The extra edge after release keeps cyc low for a cycle and avoids a double assignment.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    @(posedge mclk_i);
    while (wb_ack !== 1'b1 && k < 50) begin
      @(posedge mclk_i);
      k++;
    end
    if (k == 50) begin
      n_errors++;
      $display("Error at %0t: no bus acknowledge", $time);
    end
    rd_dat = rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk_i);
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk_reg(rd_dat, exp);
  endtask : rdchk

  task automatic setfmt(input logic [31:0] v);
    wb(1'b1, `UST_OFF_FMT, v);
    fmt = ust_fmt_t'(v);
  endtask : setfmt

  task automatic arm(input ust_mode_t m, input logic use_tx);
    wb(1'b1, `UST_OFF_CTRL, {26'h0, m, 1'b0, use_tx, 1'b1});
    n_trig = 0;
  endtask : arm

  // Symbols go back to back; the long gap after the last one closes the frame.
  task automatic frame(input logic tx, input logic [8:0] q[$]);
    foreach (q[i]) begin
      if (tx) begin
        txm.send(q[i], 1'b0, 1'b0, (i == q.size() - 1) ? 64 : 0);
      end else begin
        rxm.send(q[i], 1'b0, 1'b0, (i == q.size() - 1) ? 64 : 0);
      end
    end
  endtask : frame

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdchk(`UST_OFF_CTRL, 32'h0000_0000);
    rdchk(`UST_OFF_DIV, 32'h0000_0364);
    rdchk(`UST_OFF_IDLE, 32'h0000_21E8);
    rdchk(`UST_OFF_SEQ, 32'h0000_1000);
    rdchk(8'h3C, 32'h0000_0000);
    done("reset");
    wb(1'b1, `UST_OFF_DIV, 32'h0000_0010);
    wb(1'b1, `UST_OFF_IDLE, 32'h0000_0020);
    setfmt(32'h0000_0003);
    arm(UST_M_START, 1'b0);
    frame(1'b0, '{9'h0A5, 9'h03C});
    chk_cnt(2);
    chk_reg({23'h0, last_word}, 32'h0000_003C);
    setfmt(32'h0000_0004);
    frame(1'b0, '{9'h1A5});
    chk_reg({23'h0, last_word}, 32'h0000_01A5);
    setfmt(32'h0000_0000);
    frame(1'b0, '{9'h015});
    chk_reg({23'h0, last_word}, 32'h0000_0015);
    setfmt(32'h0000_0023);
    frame(1'b0, '{9'h05A, 9'h0C3});
    chk_reg({23'h0, last_word}, 32'h0000_00C3);
    setfmt(32'h0000_0043);
    frame(1'b0, '{9'h03C, 9'h096});
    chk_reg({23'h0, last_word}, 32'h0000_0096);
    chk_cnt(8);
    setfmt(32'h0000_0003);
    done("start");
    arm(UST_M_START, 1'b1);
    frame(1'b0, '{9'h0A5});
    chk_cnt(0);
    frame(1'b1, '{9'h0A5});
    chk_cnt(1);
    done("source");
    arm(UST_M_FRAME, 1'b0);
    frame(1'b0, '{9'h011, 9'h022, 9'h033});
    chk_cnt(1);
    done("frame");
    wb(1'b1, `UST_OFF_SEQ, 32'h0000_1002);
    arm(UST_M_SYMBOL, 1'b0);
    frame(1'b0, '{9'h001, 9'h002, 9'h003, 9'h004});
    chk_cnt(1);
    done("symbol");
    wb(1'b1, `UST_OFF_SEQ, 32'h0000_1001);
    wb(1'b1, `UST_OFF_PAT0, 32'h01FF_0055);
    wb(1'b1, `UST_OFF_PAT0 + 8'h04, 32'h00F0_00E0);
    rdchk(`UST_OFF_SEQ, 32'h0000_2001);
    arm(UST_M_PATTERN, 1'b0);
    frame(1'b0, '{9'h0AA, 9'h055, 9'h0E6});
    chk_cnt(1);
    frame(1'b0, '{9'h055, 9'h0E6, 9'h0AA});
    chk_cnt(1);
    wb(1'b1, `UST_OFF_PAT3, 32'h0000_0000);
    rdchk(`UST_OFF_SEQ, 32'h0000_4001);
    done("pattern");
    wb(1'b1, `UST_OFF_PAT0, 32'h00FF_0033);
    arm(UST_M_ANY, 1'b0);
    frame(1'b0, '{9'h011, 9'h033, 9'h044});
    chk_cnt(1);
    done("any");
    setfmt(32'h0000_000B);
    arm(UST_M_PERR, 1'b0);
    rxm.send(9'h0A5, 1'b0, 1'b0, 64);
    rxm.send(9'h0A5, 1'b1, 1'b0, 64);
    chk_cnt(1);
    rdchk(`UST_OFF_FDATA, 32'h0100_10A5);
    rdchk(`UST_OFF_FSTART, 32'hFFFF_FF57);
    rdchk(`UST_OFF_STAT, 32'h0000_0001);
    wb(1'b1, `UST_OFF_STAT, 32'h0000_0001);
    rdchk(`UST_OFF_STAT, 32'h0000_0000);
    setfmt(32'h0000_0013);
    arm(UST_M_PERR, 1'b0);
    rxm.send(9'h0A5, 1'b0, 1'b0, 64);
    chk_cnt(0);
    done("parity");
    setfmt(32'h0000_0003);
    arm(UST_M_FERR, 1'b0);
    rxm.send(9'h0A5, 1'b0, 1'b1, 64);
    chk_cnt(1);
    arm(UST_M_BREAK, 1'b0);
    rxm.send(9'h000, 1'b0, 1'b1, 64);
    rxm.send(9'h0A5, 1'b0, 1'b1, 64);
    chk_cnt(1);
    done("errors");
    end_of_test();
  end
endmodule : ust_trigger_tb_top
